// >>> hw/psv_pkg.sv
package psv_pkg;

    // Program counter geometry
    localparam int PC_W = 13;
    localparam int WORD_W = 7;
    localparam int PAGE_W = PC_W - WORD_W;
    localparam int PAGE_LSB = 7;
    localparam int WORD_MSB = 6;
    localparam logic [WORD_W-1:0] WORD_LAST = 7'h7F;

    // Program memory word layout
    localparam int ROM_W = 10;
    localparam int TABLE_W = 8;
    localparam int TABLE_MSB = 7;

    // Page map
    localparam logic [PAGE_W-1:0] PAGE_VECTOR = 6'h01;
    localparam logic [PAGE_W-1:0] PAGE_CALL = 6'h02;
    localparam logic [PC_W-1:0] VEC_AREA_FIRST = 13'h0080;
    localparam logic [PC_W-1:0] VEC_AREA_LAST = 13'h00FF;
    localparam logic [PC_W-1:0] CALL_AREA_FIRST = 13'h0100;
    localparam logic [PC_W-1:0] CALL_AREA_LAST = 13'h017F;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

    // Sources, in priority order: index 0 is served first
    localparam int NUM_SRC = 4;
    localparam int SRC_EXT = 0;
    localparam int SRC_T1 = 1;
    localparam int SRC_T2 = 2;
    localparam int SRC_T3 = 3;

    // In-page vector offsets, one per source
    localparam logic [WORD_W-1:0] VEC_OFS_EXT = 7'h00;
    localparam logic [WORD_W-1:0] VEC_OFS_T1 = 7'h04;
    localparam logic [WORD_W-1:0] VEC_OFS_T2 = 7'h06;
    localparam logic [WORD_W-1:0] VEC_OFS_T3 = 7'h08;

    // Interrupt control registers, 4 bits each
    localparam int CTRL_W = 4;
    localparam int CTRL1_EXT_BIT = 0;
    localparam int CTRL1_T1_BIT = 2;
    localparam int CTRL1_T2_BIT = 3;
    localparam int CTRL2_T3_BIT = 0;
    localparam logic [CTRL_W-1:0] CTRL1_RESET = 4'h0;
    localparam logic [CTRL_W-1:0] CTRL2_RESET = 4'h0;

    // External pin edge selection
    localparam logic [1:0] EXT_FALL = 2'h0;
    localparam logic [1:0] EXT_RISE = 2'h1;
    localparam logic [1:0] EXT_BOTH = 2'h2;

    // Context save widths
    localparam int DP_W = 10;
    localparam int ACC_W = 4;

endpackage : psv_pkg

// >>> hw/psv_pend_flag.sv
`timescale 1ns/10ps
module psv_pend_flag (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    // Flag control
    input wire logic set_i,
    input wire logic clr_i,
    // Flag state
    output logic flag_o
);

    logic flag_q;

    // Sticky request flag; a set in the clear cycle wins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (en_i) begin
            if (set_i) begin
                flag_q <= 1'b1;
            end else if (clr_i) begin
                flag_q <= 1'b0;
            end
        end
    end

    assign flag_o = flag_q;

endmodule : psv_pend_flag

// >>> hw/psv_sequencer.sv
`timescale 1ns/10ps
module psv_sequencer (
    // Clock, reset, clock enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    // Instruction completion and flow control
    input wire logic step_i,
    input wire logic [1:0] inst_len_i,
    input wire logic load_i,
    input wire logic [psv_pkg::PC_W-1:0] load_addr_i,
    input wire logic page_two_call_op_i,
    input wire logic [psv_pkg::WORD_W-1:0] call_word_i,
    input wire logic return_from_service_op_i,
    // Table read
    input wire logic table_read_op_i,
    input wire logic [psv_pkg::PC_W-1:0] table_addr_i,
    input wire logic [psv_pkg::ROM_W-1:0] rom_word_i,
    // Global enable instructions
    input wire logic global_unmask_op_i,
    input wire logic global_mask_op_i,
    // Skip tests, one bit per source
    input wire logic [psv_pkg::NUM_SRC-1:0] skip_test_i,
    // Interrupt sources
    input wire logic ext_pin_i,
    input wire logic [1:0] ext_edge_sel_i,
    input wire logic timer_one_uflow_i,
    input wire logic timer_two_uflow_i,
    input wire logic timer_three_uflow_i,
    // Control register writes
    input wire logic ctrl_first_wr_i,
    input wire logic ctrl_second_wr_i,
    input wire logic [psv_pkg::CTRL_W-1:0] ctrl_data_i,
    input wire logic power_down_i,
    // Context to save on interrupt
    input wire logic [psv_pkg::DP_W-1:0] dp_i,
    input wire logic carry_i,
    input wire logic skip_i,
    input wire logic [psv_pkg::ACC_W-1:0] reg_a_i,
    input wire logic [psv_pkg::ACC_W-1:0] reg_b_i,
    // Program counter
    output logic [psv_pkg::PC_W-1:0] pc_o,
    output logic [psv_pkg::PAGE_W-1:0] page_select_field_o,
    output logic [psv_pkg::WORD_W-1:0] in_page_word_field_o,
    output logic [psv_pkg::PC_W-1:0] rom_addr_o,
    output logic in_vector_area_o,
    output logic in_call_page_o,
    // Table read result
    output logic [psv_pkg::TABLE_W-1:0] table_data_o,
    output logic table_valid_o,
    // Interrupt state
    output logic irq_take_o,
    output logic [psv_pkg::NUM_SRC-1:0] irq_src_o,
    output logic [psv_pkg::PC_W-1:0] ret_addr_o,
    output logic global_irq_enable_flag_o,
    output logic ext_pending_flag_o,
    output logic timer_one_pending_o,
    output logic timer_two_pending_o,
    output logic timer_three_pending_o,
    output logic [psv_pkg::NUM_SRC-1:0] skip_taken_o,
    // Control registers
    output logic [psv_pkg::CTRL_W-1:0] irq_control_first_o,
    output logic [psv_pkg::CTRL_W-1:0] irq_control_second_o,
    // Context save register
    output logic [psv_pkg::DP_W-1:0] ctx_dp_o,
    output logic ctx_carry_o,
    output logic ctx_skip_o,
    output logic [psv_pkg::ACC_W-1:0] ctx_reg_a_o,
    output logic [psv_pkg::ACC_W-1:0] ctx_reg_b_o
);

    logic [psv_pkg::PC_W-1:0] pc_q;
    logic [psv_pkg::PC_W-1:0] pc_d;
    logic [psv_pkg::PC_W-1:0] seq_pc;
    logic [psv_pkg::PC_W-1:0] vec_addr;
    logic [psv_pkg::PC_W-1:0] rom_addr_q;
    logic [psv_pkg::PC_W-1:0] ret_addr_q;
    logic [psv_pkg::CTRL_W-1:0] ctrl1_q;
    logic [psv_pkg::CTRL_W-1:0] ctrl2_q;
    logic [psv_pkg::NUM_SRC-1:0] irq_en;
    logic [psv_pkg::NUM_SRC-1:0] pend;
    logic [psv_pkg::NUM_SRC-1:0] req_set;
    logic [psv_pkg::NUM_SRC-1:0] ready;
    logic [psv_pkg::NUM_SRC-1:0] grant;
    logic [psv_pkg::NUM_SRC-1:0] skip_hit;
    logic [psv_pkg::NUM_SRC-1:0] flag_clr;
    logic [psv_pkg::NUM_SRC-1:0] irq_src_q;
    logic [psv_pkg::NUM_SRC-1:0] skip_taken_q;
    logic [psv_pkg::TABLE_W-1:0] table_data_q;
    logic gie_q;
    logic arm_q;
    logic take;
    logic take_q;
    logic tab_pend_q;
    logic tab_valid_q;
    logic ext_prev_q;
    logic ext_prev_ok_q;
    logic ext_event;
    logic vec_area_q;
    logic call_page_q;
    logic [psv_pkg::DP_W-1:0] ctx_dp_q;
    logic ctx_carry_q;
    logic ctx_skip_q;
    logic [psv_pkg::ACC_W-1:0] ctx_a_q;
    logic [psv_pkg::ACC_W-1:0] ctx_b_q;

    // Enable bits gathered in priority order
    assign irq_en[psv_pkg::SRC_EXT] = ctrl1_q[psv_pkg::CTRL1_EXT_BIT];
    assign irq_en[psv_pkg::SRC_T1] = ctrl1_q[psv_pkg::CTRL1_T1_BIT];
    assign irq_en[psv_pkg::SRC_T2] = ctrl1_q[psv_pkg::CTRL1_T2_BIT];
    assign irq_en[psv_pkg::SRC_T3] = ctrl2_q[psv_pkg::CTRL2_T3_BIT];

    // External pin change detector; first sample after reset only primes it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_prev_q <= 1'b0;
            ext_prev_ok_q <= 1'b0;
        end else if (en_i) begin
            ext_prev_q <= ext_pin_i;
            ext_prev_ok_q <= 1'b1;
        end
    end

    // Edge selection for the external request
    always_comb begin
        ext_event = 1'b0;
        if (ext_prev_ok_q) begin
            unique case (ext_edge_sel_i)
                psv_pkg::EXT_FALL: ext_event = ext_prev_q & ~ext_pin_i;
                psv_pkg::EXT_RISE: ext_event = ~ext_prev_q & ext_pin_i;
                psv_pkg::EXT_BOTH: ext_event = ext_prev_q ^ ext_pin_i;
                default: ext_event = 1'b0;
            endcase
        end
    end

    // Activating events per source, independent of any enable
    assign req_set[psv_pkg::SRC_EXT] = ext_event;
    assign req_set[psv_pkg::SRC_T1] = timer_one_uflow_i;
    assign req_set[psv_pkg::SRC_T2] = timer_two_uflow_i;
    assign req_set[psv_pkg::SRC_T3] = timer_three_uflow_i;

    // Acceptance needs flag, enable bit and global enable together
    assign ready = pend & irq_en & {psv_pkg::NUM_SRC{gie_q}};

    // Fixed priority: lowest index wins
    always_comb begin
        grant = '0;
        for (int i = psv_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (ready[i]) begin
                grant = '0;
                grant[i] = 1'b1;
            end
        end
    end

    // Interrupts are taken at an instruction boundary
    assign take = step_i & (|ready);

    // Vector address in page 1 for the granted source
    always_comb begin
        vec_addr = {psv_pkg::PAGE_VECTOR, psv_pkg::VEC_OFS_EXT};
        if (grant[psv_pkg::SRC_T1]) begin
            vec_addr = {psv_pkg::PAGE_VECTOR, psv_pkg::VEC_OFS_T1};
        end
        if (grant[psv_pkg::SRC_T2]) begin
            vec_addr = {psv_pkg::PAGE_VECTOR, psv_pkg::VEC_OFS_T2};
        end
        if (grant[psv_pkg::SRC_T3]) begin
            vec_addr = {psv_pkg::PAGE_VECTOR, psv_pkg::VEC_OFS_T3};
        end
    end

    // Skip test succeeds only with flag set and enable bit clear
    assign skip_hit = skip_test_i & pend & ~irq_en & {psv_pkg::NUM_SRC{step_i}};

    // Clear only the served source, or the skipped one
    assign flag_clr = (grant & {psv_pkg::NUM_SRC{take}}) | skip_hit;

    // One request flag per source
    generate
        for (genvar g = 0; g < psv_pkg::NUM_SRC; g++) begin : g_pend
            psv_pend_flag u_flag (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .en_i(en_i),
                .set_i(req_set[g]),
                .clr_i(flag_clr[g]),
                .flag_o(pend[g])
            );
        end
    endgenerate

    // Next program counter: sequential step carries into the page field
    assign seq_pc = pc_q + {{(psv_pkg::PC_W - 2){1'b0}}, inst_len_i};

    // Program counter source selection: load, then page-two call, then sequential step
    always_comb begin
        pc_d = pc_q;
        if (step_i) begin
            if (load_i) begin
                pc_d = load_addr_i;
            end else if (page_two_call_op_i) begin
                pc_d = {psv_pkg::PAGE_CALL, call_word_i};
            end else begin
                pc_d = seq_pc;
            end
        end
    end

    // Program counter register; the vector overrides the step target
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_q <= psv_pkg::PC_RESET;
        end else if (en_i) begin
            if (take) begin
                pc_q <= vec_addr;
            end else begin
                pc_q <= pc_d;
            end
        end
    end

    // Address where execution resumes after service
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ret_addr_q <= psv_pkg::PC_RESET;
        end else if (en_i && take) begin
            ret_addr_q <= pc_d;
        end
    end

    // Page map decode of the new counter value
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vec_area_q <= 1'b0;
            call_page_q <= 1'b0;
        end else if (en_i) begin
            vec_area_q <= (pc_d >= psv_pkg::VEC_AREA_FIRST) && (pc_d <= psv_pkg::VEC_AREA_LAST);
            call_page_q <= (pc_d >= psv_pkg::CALL_AREA_FIRST) && (pc_d <= psv_pkg::CALL_AREA_LAST);
            if (take) begin
                vec_area_q <= 1'b1;
                call_page_q <= 1'b0;
            end
        end
    end

    // Memory address: table address for one cycle, otherwise the counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rom_addr_q <= psv_pkg::PC_RESET;
            tab_pend_q <= 1'b0;
        end else if (en_i) begin
            tab_pend_q <= table_read_op_i & ~take;
            if (table_read_op_i && !take) begin
                rom_addr_q <= table_addr_i;
            end else if (take) begin
                rom_addr_q <= vec_addr;
            end else begin
                rom_addr_q <= pc_d;
            end
        end
    end

    // Capture the low data bits of the addressed word
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            table_data_q <= '0;
            tab_valid_q <= 1'b0;
        end else if (en_i) begin
            tab_valid_q <= tab_pend_q;
            if (tab_pend_q) begin
                table_data_q <= rom_word_i[psv_pkg::TABLE_MSB:0];
            end
        end
    end

    // Global enable with one-instruction delay on unmask
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gie_q <= 1'b0;
            arm_q <= 1'b0;
        end else if (en_i) begin
            if (take) begin
                gie_q <= 1'b0;
                arm_q <= 1'b0;
            end else if (step_i && global_mask_op_i) begin
                gie_q <= 1'b0;
                arm_q <= 1'b0;
            end else if (step_i && global_unmask_op_i) begin
                arm_q <= 1'b1;
            end else if (step_i && arm_q) begin
                gie_q <= 1'b1;
                arm_q <= 1'b0;
            end
        end
    end

    // Interrupt control registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl1_q <= psv_pkg::CTRL1_RESET;
            ctrl2_q <= psv_pkg::CTRL2_RESET;
        end else if (en_i) begin
            if (power_down_i) begin
                ctrl1_q <= psv_pkg::CTRL1_RESET;
            end else if (ctrl_first_wr_i) begin
                ctrl1_q <= ctrl_data_i;
            end
            if (ctrl_second_wr_i) begin
                ctrl2_q <= ctrl_data_i;
            end
        end
    end

    // Context save register, single level
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctx_dp_q <= '0;
            ctx_carry_q <= 1'b0;
            ctx_skip_q <= 1'b0;
            ctx_a_q <= '0;
            ctx_b_q <= '0;
        end else if (en_i && take) begin
            ctx_dp_q <= dp_i;
            ctx_carry_q <= carry_i;
            ctx_skip_q <= skip_i;
            ctx_a_q <= reg_a_i;
            ctx_b_q <= reg_b_i;
        end
    end

    // Take and skip pulses for the sequencer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            take_q <= 1'b0;
            irq_src_q <= '0;
            skip_taken_q <= '0;
        end else if (en_i) begin
            take_q <= take;
            irq_src_q <= take ? grant : '0;
            skip_taken_q <= skip_hit;
        end
    end

    // Outputs straight from flip-flops
    assign pc_o = pc_q;
    assign page_select_field_o = pc_q[psv_pkg::PC_W-1:psv_pkg::PAGE_LSB];
    assign in_page_word_field_o = pc_q[psv_pkg::WORD_MSB:0];
    assign rom_addr_o = rom_addr_q;
    assign in_vector_area_o = vec_area_q;
    assign in_call_page_o = call_page_q;
    assign table_data_o = table_data_q;
    assign table_valid_o = tab_valid_q;
    assign irq_take_o = take_q;
    assign irq_src_o = irq_src_q;
    assign ret_addr_o = ret_addr_q;
    assign global_irq_enable_flag_o = gie_q;
    assign ext_pending_flag_o = pend[psv_pkg::SRC_EXT];
    assign timer_one_pending_o = pend[psv_pkg::SRC_T1];
    assign timer_two_pending_o = pend[psv_pkg::SRC_T2];
    assign timer_three_pending_o = pend[psv_pkg::SRC_T3];
    assign skip_taken_o = skip_taken_q;
    assign irq_control_first_o = ctrl1_q;
    assign irq_control_second_o = ctrl2_q;
    assign ctx_dp_o = ctx_dp_q;
    assign ctx_carry_o = ctx_carry_q;
    assign ctx_skip_o = ctx_skip_q;
    assign ctx_reg_a_o = ctx_a_q;
    assign ctx_reg_b_o = ctx_b_q;

endmodule : psv_sequencer

// >>> testbench/psv_monitor.sv
`timescale 1ns/10ps
// Port checker for the sequencer and its interrupt logic
module psv_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watched inputs
    input wire logic en_i,
    input wire logic power_down_i,
    input wire logic [psv_pkg::ROM_W-1:0] rom_word_i,
    // Watched outputs
    input wire logic [psv_pkg::PC_W-1:0] pc_o,
    input wire logic [psv_pkg::PAGE_W-1:0] page_select_field_o,
    input wire logic [psv_pkg::WORD_W-1:0] in_page_word_field_o,
    input wire logic in_vector_area_o,
    input wire logic in_call_page_o,
    input wire logic [psv_pkg::TABLE_W-1:0] table_data_o,
    input wire logic table_valid_o,
    input wire logic irq_take_o,
    input wire logic [psv_pkg::NUM_SRC-1:0] irq_src_o,
    input wire logic global_irq_enable_flag_o,
    input wire logic ext_pending_flag_o,
    input wire logic timer_one_pending_o,
    input wire logic timer_three_pending_o,
    input wire logic [psv_pkg::NUM_SRC-1:0] skip_taken_o,
    input wire logic [psv_pkg::CTRL_W-1:0] irq_control_first_o,
    input wire logic [psv_pkg::CTRL_W-1:0] irq_control_second_o
);
    // One clock domain for every check
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Served source and its vector
    AST_VECTOR: assert property (
        irq_take_o |-> pc_o == (irq_src_o[0] ? 13'h0080 : irq_src_o[1] ? 13'h0084 :
        irq_src_o[2] ? 13'h0086 : 13'h0088)) else $error("vector address wrong");
    AST_GIE_OFF: assert property (
        irq_take_o |-> !global_irq_enable_flag_o && $past(global_irq_enable_flag_o))
        else $error("global enable not cleared on take");
    AST_ONE_SRC: assert property (
        irq_take_o |-> $onehot(irq_src_o)) else $error("served source not one-hot");
    AST_EXT_COND: assert property (
        irq_src_o[0] |-> $past(ext_pending_flag_o && irq_control_first_o[0]))
        else $error("external served without request and enable");
    AST_T3_COND: assert property (
        irq_src_o[3] |-> $past(timer_three_pending_o && irq_control_second_o[0]))
        else $error("timer three served without request and enable");
    AST_PRIO: assert property (
        irq_src_o[1] |-> !$past(ext_pending_flag_o && irq_control_first_o[0]))
        else $error("timer one served ahead of external");
    AST_OTHERS_KEPT: assert property (
        irq_src_o[0] |-> timer_one_pending_o == $past(timer_one_pending_o))
        else $error("other request flag disturbed");
    AST_FIELDS: assert property (
        page_select_field_o == pc_o[12:7] && in_page_word_field_o == pc_o[6:0])
        else $error("page or word field wrong");
    AST_AREAS: assert property (
        in_vector_area_o == (pc_o inside {[psv_pkg::VEC_AREA_FIRST:psv_pkg::VEC_AREA_LAST]}) &&
        in_call_page_o == (pc_o inside {[psv_pkg::CALL_AREA_FIRST:psv_pkg::CALL_AREA_LAST]}))
        else $error("area flag wrong");
    AST_SKIP_T1: assert property (
        skip_taken_o[1] |-> !$past(irq_control_first_o[2])) else $error("skip with enable set");
    AST_TABLE: assert property (
        table_valid_o |-> table_data_o == $past(rom_word_i[7:0])) else $error("table data wrong");
    AST_PDOWN: assert property (
        en_i && power_down_i |=> irq_control_first_o == 4'h0) else $error("power-down left control set");
endmodule : psv_monitor

bind psv_sequencer psv_monitor i_mon (.*);

// >>> testbench/psv_rom_model.sv
`timescale 1ns/10ps
// Program memory stand-in with a fixed pattern per address
module psv_rom_model (
    // Fetch address
    input wire logic [psv_pkg::PC_W-1:0] addr_i,
    // Program word
    output logic [psv_pkg::ROM_W-1:0] word_o
);
    // Ten-bit word for any address, upper bits differ from the table byte
    assign word_o = addr_i[9:0] ^ 10'h2A5;
endmodule : psv_rom_model

// >>> testbench/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("unexpected %s: expected %h seen %h", nm, exp, got); \
        end \
    end
module testbench;
    // Inputs, with the outputs of matching widths
    logic clk_i, rst_i, en_i, step_i, load_i, page_two_call_op_i, return_from_service_op_i;
    logic table_read_op_i, global_unmask_op_i, global_mask_op_i, ext_pin_i, power_down_i, carry_i, skip_i;
    logic timer_one_uflow_i, timer_two_uflow_i, timer_three_uflow_i, ctrl_first_wr_i, ctrl_second_wr_i;
    logic [1:0] inst_len_i, ext_edge_sel_i;
    logic [6:0] call_word_i, in_page_word_field_o;
    logic [12:0] load_addr_i, table_addr_i, pc_o, rom_addr_o, ret_addr_o;
    logic [9:0] rom_word_i, dp_i, ctx_dp_o;
    logic [3:0] skip_test_i, ctrl_data_i, reg_a_i, reg_b_i, ctx_reg_a_o, ctx_reg_b_o;
    // Outputs
    logic [5:0] page_select_field_o;
    logic in_vector_area_o, in_call_page_o, table_valid_o, irq_take_o, global_irq_enable_flag_o;
    logic ext_pending_flag_o, timer_one_pending_o, timer_two_pending_o, timer_three_pending_o;
    logic ctx_carry_o, ctx_skip_o;
    logic [7:0] table_data_o;
    logic [3:0] irq_src_o, skip_taken_o, irq_control_first_o, irq_control_second_o;
    int mismatches = 0;
    int cmp_count = 0;
    // Ordinary steps: length, load, target, call, call word, expected counter
    typedef struct packed {logic [1:0] len; logic ld; logic [12:0] la; logic cl; logic [6:0] cw;
        logic [12:0] pc;} psv_row_s;
    psv_row_s rows [9] = '{'{2'h0, 1'b1, 13'h007E, 1'b0, 7'h00, 13'h007E},
        '{2'h1, 1'b0, 13'h0000, 1'b0, 7'h00, 13'h007F}, '{2'h1, 1'b0, 13'h0000, 1'b0, 7'h00, 13'h0080},
        '{2'h0, 1'b1, 13'h00FE, 1'b0, 7'h00, 13'h00FE}, '{2'h2, 1'b0, 13'h0000, 1'b0, 7'h00, 13'h0100},
        '{2'h0, 1'b1, 13'h1F80, 1'b0, 7'h00, 13'h1F80}, '{2'h1, 1'b0, 13'h0000, 1'b1, 7'h05, 13'h0105},
        '{2'h0, 1'b1, 13'h1FFF, 1'b0, 7'h00, 13'h1FFF}, '{2'h1, 1'b0, 13'h0000, 1'b0, 7'h00, 13'h0000}};
    logic [12:0] vec [2] = '{13'h0084, 13'h0088};

    // Device and program memory
    psv_sequencer i_dut (.*);
    psv_rom_model i_rom (.addr_i(rom_addr_o), .word_o(rom_word_i));

    // Free-running clock
    initial clk_i = 1'b0;
    always #12.5 clk_i = ~clk_i;

    // One instruction completes; returns just after its edge
    task automatic step_op(input logic [1:0] len, input logic ld, input logic [12:0] la, input logic cl,
        input logic [6:0] cw, input logic um, input logic mk, input logic [3:0] sk);
        @(posedge clk_i);
        {inst_len_i, load_i, load_addr_i, page_two_call_op_i} <= {len, ld, la, cl};
        {call_word_i, global_unmask_op_i, global_mask_op_i, skip_test_i} <= {cw, um, mk, sk};
        step_i <= 1'b1;
        @(posedge clk_i);
        step_i <= 1'b0;
        #1;
    endtask : step_op

    // Plain one-word instruction
    task automatic plain(input logic um, input logic mk, input logic [3:0] sk);
        step_op(2'h1, 1'b0, 13'h0000, 1'b0, 7'h00, um, mk, sk);
    endtask : plain

    // Control register write
    task automatic wr_ctrl(input logic sec, input logic [3:0] d);
        @(posedge clk_i);
        {ctrl_first_wr_i, ctrl_second_wr_i, ctrl_data_i} <= {!sec, sec, d};
        @(posedge clk_i);
        {ctrl_first_wr_i, ctrl_second_wr_i} <= 2'h0;
        #1;
    endtask : wr_ctrl

    // Verdict and end of run
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        stop_test();
    end

    // Main sequence
    initial begin
        {step_i, load_i, page_two_call_op_i, return_from_service_op_i, table_read_op_i, global_unmask_op_i,
            global_mask_op_i, ext_pin_i, power_down_i, carry_i, skip_i, timer_one_uflow_i, timer_two_uflow_i,
            timer_three_uflow_i, ctrl_first_wr_i, ctrl_second_wr_i, inst_len_i, call_word_i, load_addr_i,
            table_addr_i, dp_i, skip_test_i, ctrl_data_i, reg_a_i, reg_b_i} = '0;
        {rst_i, en_i, ext_edge_sel_i} = {1'b1, 1'b1, 2'h1};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        `CHK("pc", 13'h0000, pc_o)
        `CHK("gie", 1'b0, global_irq_enable_flag_o)
        `CHK("flags", 4'h0, {ext_pending_flag_o, timer_one_pending_o, timer_two_pending_o, timer_three_pending_o})
        `CHK("ctrl1", 4'h0, irq_control_first_o)
        $display("test reset done");
        foreach (rows[i]) begin
            step_op(rows[i].len, rows[i].ld, rows[i].la, rows[i].cl, rows[i].cw, 1'b0, 1'b0, 4'h0);
            `CHK("pc", rows[i].pc, pc_o)
            `CHK("page", rows[i].pc[12:7], page_select_field_o)
            `CHK("vec area", 1'(rows[i].pc inside {[13'h0080:13'h00FF]}), in_vector_area_o)
        end
        $display("test steps done");
        wr_ctrl(1'b0, 4'hD);
        `CHK("ctrl1", 4'hD, irq_control_first_o)
        wr_ctrl(1'b1, 4'h1);
        @(posedge clk_i);
        power_down_i <= 1'b1;
        @(posedge clk_i);
        power_down_i <= 1'b0;
        #1;
        `CHK("ctrl after pd", 8'h01, {irq_control_first_o, irq_control_second_o})
        wr_ctrl(1'b0, 4'hD);
        @(posedge clk_i);
        {ext_pin_i, timer_one_uflow_i, timer_three_uflow_i, dp_i, reg_a_i, reg_b_i} <= {3'h7, 10'h3C1, 4'h9, 4'h6};
        {carry_i, skip_i} <= 2'h3;
        @(posedge clk_i);
        {timer_one_uflow_i, timer_three_uflow_i} <= 2'h0;
        plain(1'b0, 1'b0, 4'h0);
        `CHK("take", 1'b0, irq_take_o)
        `CHK("pending", 3'h7, {ext_pending_flag_o, timer_one_pending_o, timer_three_pending_o})
        plain(1'b1, 1'b0, 4'h0);
        `CHK("gie delayed", 1'b0, global_irq_enable_flag_o)
        plain(1'b0, 1'b0, 4'h0);
        `CHK("gie set", 2'h2, {global_irq_enable_flag_o, irq_take_o})
        step_op(2'h1, 1'b1, 13'h0300, 1'b0, 7'h00, 1'b0, 1'b0, 4'h0);
        `CHK("ext vector", 13'h0080, pc_o)
        `CHK("src", 5'h11, {irq_take_o, irq_src_o})
        `CHK("gie off", 1'b0, global_irq_enable_flag_o)
        `CHK("flags", 3'h3, {ext_pending_flag_o, timer_one_pending_o, timer_three_pending_o})
        `CHK("ret", 13'h0300, ret_addr_o)
        `CHK("ctx", 20'hF065B, {ctx_dp_o, ctx_reg_a_o, ctx_reg_b_o, ctx_carry_o, ctx_skip_o})
        for (int k = 0; k < 2; k++) begin
            plain(1'b1, 1'b0, 4'h0);
            plain(1'b0, 1'b0, 4'h0);
            plain(1'b0, 1'b0, 4'h0);
            `CHK("vector", vec[k], pc_o)
        end
        $display("test interrupts done");
        wr_ctrl(1'b0, 4'h5);
        @(posedge clk_i);
        {timer_one_uflow_i, timer_two_uflow_i} <= 2'h3;
        @(posedge clk_i);
        {timer_one_uflow_i, timer_two_uflow_i} <= 2'h0;
        plain(1'b0, 1'b0, 4'h6);
        `CHK("skip", 4'h4, skip_taken_o)
        `CHK("t1 t2", 2'h2, {timer_one_pending_o, timer_two_pending_o})
        wr_ctrl(1'b0, 4'h0);
        plain(1'b0, 1'b0, 4'h2);
        `CHK("skip t1", 5'h4, {skip_taken_o, timer_one_pending_o})
        // Falling edge mode sets the external flag, which the skip test then clears
        @(posedge clk_i);
        {ext_edge_sel_i, ext_pin_i} <= {2'h0, 1'b0};
        plain(1'b0, 1'b0, 4'h1);
        `CHK("ext fall skip", 5'h02, {skip_taken_o, ext_pending_flag_o})
        // Either-edge mode reacts to a rising pin
        @(posedge clk_i);
        {ext_edge_sel_i, ext_pin_i} <= {2'h2, 1'b1};
        @(posedge clk_i);
        #1;
        `CHK("ext both", 1'b1, ext_pending_flag_o)
        plain(1'b1, 1'b0, 4'h0);
        plain(1'b0, 1'b0, 4'h0);
        `CHK("unmask", 1'b1, global_irq_enable_flag_o)
        plain(1'b0, 1'b1, 4'h0);
        `CHK("mask", 1'b0, global_irq_enable_flag_o)
        $display("test skips done");
        @(posedge clk_i);
        {table_read_op_i, table_addr_i} <= {1'b1, 13'h1ABC};
        @(posedge clk_i);
        table_read_op_i <= 1'b0;
        #1;
        `CHK("table addr", 13'h1ABC, rom_addr_o)
        @(posedge clk_i);
        #1;
        `CHK("table data", {1'b1, 8'(13'h1ABC ^ 13'h02A5)}, {table_valid_o, table_data_o})
        $display("test table done");
        // Reset in mid-run drops counter, global enable and a pending flag
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        `CHK("pc again", 13'h0000, pc_o)
        `CHK("reset again", 3'h0, {global_irq_enable_flag_o, ext_pending_flag_o, table_valid_o})
        $display("test reset again done");
        stop_test();
    end
endmodule : testbench
